//--- core/pz_regs.svh
// register offsets, reset values and timing counts of the power-zone sequencer
`ifndef PZ_REGS_SVH
`define PZ_REGS_SVH

`define PZ_OFS_CONFIG       8'h00
`define PZ_OFS_THRESH       8'h04
`define PZ_OFS_FIXED        8'h08
`define PZ_OFS_STATUS       8'h0c

`define PZ_RST_PHASES       4'h8
`define PZ_RST_HYST         8'h10
`define PZ_RST_DELAY        8'h14
`define PZ_RST_THRESH       32'h80604020
`define PZ_RST_FREQ         8'h40
`define PZ_THR_OFF          8'hff

`define PZ_CLK_KHZ          10000
`define PZ_SAMPLE_US        10
`define PZ_SAMPLE_CYC       ((`PZ_SAMPLE_US * `PZ_CLK_KHZ) / 1000)

`define PZ_RESP_OKAY        2'b00
`define PZ_RESP_SLVERR      2'b10

`endif

//--- core/pz_pkg.sv
// types shared by the power-zone sequencer modules
`default_nettype none
package pz_pkg;
   typedef enum logic [1:0] {
      PZ_LVL_LOW  = 2'b00,
      PZ_LVL_MID  = 2'b01,
      PZ_LVL_HIGH = 2'b10
   } pz_level_type;

   typedef enum logic [1:0] {
      PZ_ST_HOLD = 2'b01,
      PZ_ST_WAIT = 2'b10
   } pz_step_type;

   typedef struct packed {
      logic [6:0]  tick_cnt;
      logic        tick;
      logic        running;
      logic [7:0]  delay_cnt;
      logic        expired;
   } pz_timer_state_type;

   typedef struct packed {
      logic [3:0]  phases;
      logic [7:0]  hyst;
      logic [7:0]  delay;
      logic [31:0] thresh;
      logic [2:0]  user_zone;
      logic        user_en;
      logic [7:0]  freq;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [2:0]  zone;
      logic [2:0]  target;
      pz_step_type step;
      logic        left_low;
      logic        good_seen;
      logic [7:0]  phase_en;
      logic        dcm;
   } pz_state_type;
endpackage
`default_nettype wire

//--- core/pz_timer_if.sv
// sample tick and shed delay handshake between sequencer and timer
`default_nettype none
interface pz_timer_if;
   logic       tick;
   logic       start;
   logic       cancel;
   logic [7:0] steps;
   logic       expired;
   modport timer (output tick, output expired,
                  input start, input cancel, input steps);
   modport seq   (input tick, input expired,
                  output start, output cancel, output steps);
endinterface
`default_nettype wire

//--- core/pz_timer.sv
// sample tick generator and shed delay counter in 10 us units
`include "pz_regs.svh"
`default_nettype none
module pz_timer (
   input  wire logic   aclk,
   input  wire logic   aresetn,
   pz_timer_if.timer   tmr
);
   import pz_pkg::*;

   localparam logic [6:0] TICK_LAST = 7'(`PZ_SAMPLE_CYC - 1);

   pz_timer_state_type r_reg;
   pz_timer_state_type r_next;

   always_comb begin
      r_next = r_reg;
      r_next.expired = 1'b0;
      r_next.tick = (r_reg.tick_cnt == TICK_LAST);
      if (r_reg.tick_cnt == TICK_LAST) begin
         r_next.tick_cnt = 7'h00;
      end else begin
         r_next.tick_cnt = r_reg.tick_cnt + 7'h01;
      end
      // delay counts whole sample periods, so it resolves to 10 us
      if (tmr.cancel) begin
         r_next.running = 1'b0;
      end else if (tmr.start) begin
         r_next.running = 1'b1;
         r_next.delay_cnt = tmr.steps;
      end else if (r_reg.running && r_reg.tick) begin
         if (r_reg.delay_cnt <= 8'h01) begin
            r_next.running = 1'b0;
            r_next.expired = 1'b1;
         end else begin
            r_next.delay_cnt = r_reg.delay_cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tmr.tick = r_reg.tick;
   assign tmr.expired = r_reg.expired;
endmodule
`default_nettype wire

//--- core/pz_zone_seq.sv
// power-zone sequencer with phase shedding and AXI4-Lite registers
`include "pz_regs.svh"
`default_nettype none
// Operation
// (RULE1) eight phases: zones map to fixed output sets
// (RULE2) smaller configs: restricted zone sets per phases
// (RULE3) zone 4 is DCM at 100 kHz
// (RULE4) available zones from straps or thresholds
// (RULE5) mid level: compare current, adjust zone automatically
// (RULE6) rising current steps down without delay
// (RULE7) falling current waits shed delay first
// (RULE8) shed delay programmable in 10 us steps
// (RULE9) step through each intermediate zone
// (RULE10) delay inserted at every single step
// (RULE11) hysteresis applies only to upward zone moves
// (RULE12) hysteresis resets to 0x10, writable
// (RULE13) disabled zones are skipped during transitions; under a high hint only zones the phase count cannot reach are skipped
// (RULE14) fixed-zone requests use same stepped transition
// (RULE15) fixed target enabled even if threshold off
// (RULE16) frequency selection readable and writable
// (RULE17) high all phases, mid auto, low fixed
// (RULE18) current sampled once every 10 us
// (RULE19) auto shedding waits for output voltage good
// (RULE20) threshold 0xff disables its zone
// (RULE21) cancelled upward step drops remaining delay
module pz_zone_seq (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  power_state_hint,
   input  wire logic [2:0]  fixed_zone_strap_on,
   input  wire logic [2:0]  fixed_zone_strap_back,
   input  wire logic [7:0]  iout_code,
   input  wire logic        vout_good,
   output logic [7:0]       phase_en,
   output logic             dcm_mode,
   output logic [2:0]       zone,
   output logic [7:0]       frequency_set
);
   import pz_pkg::*;

   pz_state_type r_reg;
   pz_state_type r_next;
   pz_timer_if   tmr ();

   pz_timer u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tmr     (tmr)
   );

   // zones each phase count can reach, bit k is zone k
   function automatic logic [4:0] zones_of(input logic [3:0] n);
      case (n)
         4'h8:                      zones_of = 5'b11111; // see (RULE1)
         4'h6, 4'h4:                zones_of = 5'b11101; // see (RULE2)
         4'h7, 4'h5, 4'h3, 4'h2:    zones_of = 5'b11001; // see (RULE2)
         4'h1:                      zones_of = 5'b10001; // see (RULE2)
         default:                   zones_of = 5'b11111;
      endcase
   endfunction

   // drive outputs enabled in a zone; output 1 is bit 0
   function automatic logic [7:0] mask_of(input logic [2:0] z,
                                          input logic [3:0] n);
      logic [7:0] all;
      all = 8'(9'h001 << n) - 8'h01;
      if (n > 4'h8 || n == 4'h0) begin
         all = 8'hff;
      end
      case (z)
         3'd0:    mask_of = all;                           // see (RULE1)
         3'd1:    mask_of = 8'h55;                         // see (RULE1)
         3'd2:    mask_of = (n == 4'h8) ? 8'h11 :
                            (n == 4'h6) ? 8'h15 : 8'h05;   // see (RULE2)
         default: mask_of = 8'h01;                         // see (RULE1)
      endcase
   endfunction

   // threshold guarding zone k: zone 4 uses byte 0, zone 1 byte 3
   function automatic logic [7:0] thr_of(input logic [31:0] t,
                                         input logic [2:0]  k);
      case (k)
         3'd1:    thr_of = t[31:24];
         3'd2:    thr_of = t[23:16];
         3'd3:    thr_of = t[15:8];
         default: thr_of = t[7:0];
      endcase
   endfunction

   // next allowed zone from z toward t, one zone at a time
   function automatic logic [2:0] step_of(input logic [2:0] z,
                                          input logic [2:0] t,
                                          input logic [4:0] ok);
      logic [2:0] c;
      logic       found;
      c = z;
      found = 1'b0;
      step_of = t;
      for (int i = 0; i < 4; i++) begin
         if (!found && c != t) begin
            c = (t > c) ? c + 3'd1 : c - 3'd1;
            if (ok[c] || c == t) begin
               step_of = c;                   // see (RULE9) (RULE13)
               found = 1'b1;
            end
         end
      end
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic       en);
      merge = en ? nw : old;
   endfunction

   logic [4:0]  sup;
   logic [4:0]  thr_ok;
   logic [4:0]  allowed;
   logic [2:0]  fixed_want;
   logic [2:0]  auto_tgt;
   logic [2:0]  tgt;
   logic        auto_on;
   logic [8:0]  lvl;
   logic        w_fire;
   logic        r_fire;
   logic        w_hit;
   logic [31:0] wd;
   logic [31:0] status;
   logic [31:0] rd;
   logic        rd_hit;

   // zone availability and target selection
   always_comb begin
      sup = zones_of(r_reg.phases);
      thr_ok[0] = 1'b1;
      for (int k = 1; k < 5; k++) begin
         thr_ok[k] = (thr_of(r_reg.thresh, 3'(k)) != `PZ_THR_OFF); // (RULE20)
      end
      auto_on = (power_state_hint == PZ_LVL_MID) && r_reg.good_seen;
      // user_zone picks the fixed zone when user_en is set, else the straps; the second strap once the hint has been other than low since reset
      if (r_reg.user_en) begin
         fixed_want = r_reg.user_zone;
      end else if (r_reg.left_low) begin
         fixed_want = fixed_zone_strap_back;                 // see (RULE4)
      end else begin
         fixed_want = fixed_zone_strap_on;                   // see (RULE4)
      end
      if (fixed_want > 3'd4) begin
         fixed_want = 3'd4;
      end
      // an unreachable fixed zone falls back toward full phase count
      for (int k = 4; k > 0; k--) begin
         if (fixed_want == 3'(k) && !sup[k]) begin
            fixed_want = 3'(k - 1);
         end
      end
      auto_tgt = 3'd0;
      for (int k = 1; k < 5; k++) begin
         lvl = {1'b0, iout_code};
         if (3'(k) > r_reg.zone) begin
            lvl = {1'b0, iout_code} + {1'b0, r_reg.hyst};   // see (RULE11)
         end
         if (sup[k] && thr_ok[k] &&
             lvl < {1'b0, thr_of(r_reg.thresh, 3'(k))}) begin
            auto_tgt = 3'(k);                               // see (RULE5)
         end
      end
      case (power_state_hint)
         PZ_LVL_LOW: begin
            // fixed target is usable even if its threshold is off
            allowed = sup & (thr_ok | (5'b00001 << fixed_want)); // (RULE15)
            tgt = fixed_want;                              // see (RULE14)
         end
         PZ_LVL_MID: begin
            allowed = sup & thr_ok;                         // see (RULE13)
            if (!auto_on) begin
               tgt = 3'd0;                                  // see (RULE19)
            end else if (tmr.tick) begin
               tgt = auto_tgt;                              // see (RULE18)
            end else begin
               tgt = r_reg.target;
            end
         end
         default: begin
            allowed = sup;
            tgt = 3'd0;                                     // see (RULE17)
         end
      endcase
   end

   // register access
   always_comb begin
      w_fire = r_reg.awready && s_axi_awvalid && s_axi_wvalid;
      r_fire = r_reg.arready && s_axi_arvalid;
      wd = s_axi_wdata;
      w_hit = (s_axi_awaddr == `PZ_OFS_CONFIG) ||
              (s_axi_awaddr == `PZ_OFS_THRESH) ||
              (s_axi_awaddr == `PZ_OFS_FIXED) ||
              (s_axi_awaddr == `PZ_OFS_STATUS);
      status = {13'h0000, (r_reg.step == PZ_ST_WAIT), power_state_hint,
                r_reg.phase_en, r_reg.dcm, r_reg.target, 1'b0, r_reg.zone};
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `PZ_OFS_CONFIG: rd = {8'h00, r_reg.delay, r_reg.hyst,
                               4'h0, r_reg.phases};
         `PZ_OFS_THRESH: rd = r_reg.thresh;
         `PZ_OFS_FIXED:  rd = {16'h0000, r_reg.freq, 4'h0,
                               r_reg.user_en, r_reg.user_zone}; // (RULE16)
         `PZ_OFS_STATUS: rd = status;
         default: begin
            rd = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // next state
   always_comb begin
      r_next = r_reg;
      tmr.start = 1'b0;
      tmr.cancel = 1'b0;
      tmr.steps = r_reg.delay;                              // see (RULE8)

      r_next.awready = s_axi_awvalid && s_axi_wvalid &&
                       !r_reg.awready && !r_reg.bvalid;
      r_next.wready = r_next.awready;
      r_next.arready = s_axi_arvalid && !r_reg.arready && !r_reg.rvalid;
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (w_fire) begin
         r_next.bvalid = 1'b1;
         r_next.bresp = w_hit ? `PZ_RESP_OKAY : `PZ_RESP_SLVERR;
         case (s_axi_awaddr)
            `PZ_OFS_CONFIG: begin
               if (s_axi_wstrb[0]) begin
                  r_next.phases = wd[3:0];
               end
               r_next.hyst = merge(r_reg.hyst, wd[15:8],
                                   s_axi_wstrb[1]);         // see (RULE12)
               r_next.delay = merge(r_reg.delay, wd[23:16],
                                    s_axi_wstrb[2]);        // see (RULE8)
            end
            `PZ_OFS_THRESH: begin
               for (int b = 0; b < 4; b++) begin
                  if (s_axi_wstrb[b]) begin
                     r_next.thresh[b*8 +: 8] = wd[b*8 +: 8]; // (RULE20)
                  end
               end
            end
            `PZ_OFS_FIXED: begin
               if (s_axi_wstrb[0]) begin
                  r_next.user_zone = wd[2:0];
                  r_next.user_en = wd[3];
               end
               r_next.freq = merge(r_reg.freq, wd[15:8],
                                   s_axi_wstrb[1]);         // see (RULE16)
            end
            default: begin
               r_next.bresp = w_hit ? `PZ_RESP_OKAY : `PZ_RESP_SLVERR;
            end
         endcase
      end
      if (r_fire) begin
         r_next.rvalid = 1'b1;
         r_next.rdata = rd;
         r_next.rresp = rd_hit ? `PZ_RESP_OKAY : `PZ_RESP_SLVERR;
      end

      if (vout_good) begin
         r_next.good_seen = 1'b1;                           // see (RULE19)
      end
      if (power_state_hint != PZ_LVL_LOW) begin
         r_next.left_low = 1'b1;                            // see (RULE4)
      end
      r_next.target = tgt;

      // sequencing: down at once, up only after the shed delay
      case (r_reg.step)
         PZ_ST_HOLD: begin
            if (tgt < r_reg.zone) begin
               r_next.zone = step_of(r_reg.zone, tgt, allowed); // (RULE6)
            end else if (tgt > r_reg.zone) begin
               tmr.start = 1'b1;                            // see (RULE7)
               r_next.step = PZ_ST_WAIT;
            end
         end
         PZ_ST_WAIT: begin
            if (tgt <= r_reg.zone) begin
               // load came back: drop the rest of the wait
               tmr.cancel = 1'b1;                           // see (RULE21)
               r_next.step = PZ_ST_HOLD;
               if (tgt < r_reg.zone) begin
                  r_next.zone = step_of(r_reg.zone, tgt, allowed); // (RULE6)
               end
            end else if (tmr.expired) begin
               // back to hold re-arms the delay for the next step
               r_next.zone = step_of(r_reg.zone, tgt, allowed); // (RULE10)
               r_next.step = PZ_ST_HOLD;
            end
         end
         default: begin
            r_next.step = PZ_ST_HOLD;
         end
      endcase

      r_next.phase_en = mask_of(r_next.zone, r_reg.phases); // see (RULE1)
      r_next.dcm = (r_next.zone == 3'd4);                   // see (RULE3)
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg <= '0;
         r_reg.phases <= `PZ_RST_PHASES;
         r_reg.hyst <= `PZ_RST_HYST;                        // see (RULE12)
         r_reg.delay <= `PZ_RST_DELAY;                      // see (RULE7)
         r_reg.thresh <= `PZ_RST_THRESH;
         r_reg.freq <= `PZ_RST_FREQ;
         r_reg.step <= PZ_ST_HOLD;
         r_reg.phase_en <= 8'hff;
      end else begin
         r_reg <= r_next;
      end
   end

   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.wready;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   assign phase_en = r_reg.phase_en;
   assign dcm_mode = r_reg.dcm;
   assign zone = r_reg.zone;
   assign frequency_set = r_reg.freq;
endmodule
`default_nettype wire

//--- tb/pz_zone_seq_chk.sv
// port-level assertions for the power-zone sequencer
`default_nettype none
module pz_zone_seq_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  power_state_hint,
   input wire logic [7:0]  phase_en,
   input wire logic        dcm_mode,
   input wire logic [2:0]  zone,
   input wire logic [7:0]  frequency_set
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_zone_dcm;
      dcm_mode == (zone == 3'h4);
   endproperty
   a_zone_dcm: assert property (p_zone_dcm)
      else $error("dcm flag and zone disagree");
   property p_deep_one;
      zone >= 3'h3 |-> phase_en == 8'h01;
   endproperty
   a_deep_one: assert property (p_deep_one)
      else $error("deep zone drives more than output one");
   property p_high_all;
      power_state_hint[1] [*8] |-> zone == 3'h0 && phase_en[0];
   endproperty
   a_high_all: assert property (p_high_all)
      else $error("high hint did not return to zone zero");
   // upward steps never come on adjacent cycles
   property p_up_gap;
      zone > $past(zone) |=> zone <= $past(zone);
   endproperty
   a_up_gap: assert property (p_up_gap)
      else $error("two upward steps on adjacent cycles");
   property p_ready_pair;
      s_axi_awready == s_axi_wready;
   endproperty
   a_ready_pair: assert property (p_ready_pair)
      else $error("write address and data readies split");
   property p_b_follows;
      s_axi_awready |=> s_axi_bvalid;
   endproperty
   a_b_follows: assert property (p_b_follows)
      else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_freq_rst;
      $rose(aresetn) |-> frequency_set == 8'h40 && phase_en == 8'hff;
   endproperty
   a_freq_rst: assert property (p_freq_rst)
      else $error("frequency or phases wrong after reset");
endmodule
bind pz_zone_seq pz_zone_seq_chk i_pz_zone_seq_chk (
   .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .power_state_hint, .phase_en, .dcm_mode, .zone, .frequency_set
);
`default_nettype wire

//--- tb/pz_stage_model.sv
// host power-state, load current and strap model on the far side
`default_nettype none
module pz_stage_model
   import pz_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic [2:0] zone,
   output logic [1:0]      hint,
   output logic [7:0]      iout,
   output logic            good,
   output logic [2:0]      strap_on,
   output logic [2:0]      strap_back
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] trail[$];
   initial begin
      hint = PZ_LVL_HIGH;
      iout = 8'h00;
      good = 1'b0;
      strap_on = 3'h4;
      strap_back = 3'h3;
   end
   // every zone change is kept so the stepping order can be checked
   always @(zone) trail.push_back(zone);
   task automatic drive(input logic [1:0] h, input logic [7:0] i,
                        input logic g);
      @(posedge aclk);
      hint <= h;
      iout <= i;
      good <= g;
   endtask
endmodule
`default_nettype wire

//--- tb/test_pz_zone_seq.sv
// self-checking bench for the power-zone sequencer
`include "pz_regs.svh"
`default_nettype none
module test_pz_zone_seq;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [1:0] LO = pz_pkg::PZ_LVL_LOW;
   localparam logic [1:0] MI = pz_pkg::PZ_LVL_MID;
   localparam logic [1:0] HI = pz_pkg::PZ_LVL_HIGH;
   localparam logic [1:0] OK = `PZ_RESP_OKAY;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready, dcm_mode;
   logic        good;
   logic [7:0]  awaddr, araddr, phase_en, frequency_set, iout;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, hint;
   logic [2:0]  zone, s_on, s_back;
   logic [15:0] cfg[11] = '{16'h501f, 16'h3007, 16'h2003, 16'h8155,
      16'h8211, 16'h6215, 16'h4205, 16'h4401, 16'h1401, 16'h7401, 16'h7301};
   int          bad_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          n;
   pz_zone_seq i_pz_zone_seq (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .power_state_hint(hint),
      .fixed_zone_strap_on(s_on), .fixed_zone_strap_back(s_back),
      .iout_code(iout), .vout_good(good), .phase_en(phase_en),
      .dcm_mode(dcm_mode), .zone(zone), .frequency_set(frequency_set));
   pz_stage_model i_pz_stage_model (.aclk(aclk), .zone(zone), .hint(hint),
      .iout(iout), .good(good), .strap_on(s_on), .strap_back(s_back));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // only trips on a hang
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 45000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: resp %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b1;
      @(posedge aclk);
      bready <= 1'b0;
      check_resp(bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b1;
      @(posedge aclk);
      rready <= 1'b0;
      check_data(rdata, exp);
      check_resp(rresp, er);
   endtask
   task automatic wait_zone(input logic [2:0] z, input int lim);
      n = 0;
      while (zone !== z && n < lim) begin
         @(posedge aclk);
         n++;
      end
      check_data(32'(zone), 32'(z));
   endtask
   task automatic stay(input logic [2:0] z, input int c);
      int m;
      m = 0;
      repeat (c) begin
         @(posedge aclk);
         if (zone !== z) m++;
      end
      check_data(32'(m), 32'h0);
   endtask
   // zones visited since the last call, one nibble each, oldest first
   task automatic check_trail(input logic [31:0] exp);
      logic [31:0] got;
      got = 32'h0;
      foreach (i_pz_stage_model.trail[k])
         got = {got[27:0], 1'b0, i_pz_stage_model.trail[k]};
      check_data(got, exp);
      i_pz_stage_model.trail.delete();
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      do_reset();
      check_data(32'(phase_en), 32'hff);
      check_data(32'(frequency_set), 32'h40);
      rd(`PZ_OFS_CONFIG, 32'h00141008, OK);
      rd(`PZ_OFS_THRESH, 32'h80604020, OK);
      rd(`PZ_OFS_FIXED, 32'h00004000, OK);
      rd(8'h10, 32'h0, `PZ_RESP_SLVERR);
      wr(8'h10, 32'h1, `PZ_RESP_SLVERR);
      wr(`PZ_OFS_STATUS, 32'hffffffff, OK);
      rd(`PZ_OFS_STATUS, 32'h0002ff00, OK);
      i_pz_stage_model.drive(MI, 8'h00, 1'b0);
      stay(3'h0, 2400);
      i_pz_stage_model.drive(MI, 8'h00, 1'b1);
      stay(3'h0, 1000);
      i_pz_stage_model.drive(MI, 8'hff, 1'b1);
      stay(3'h0, 600);
      i_pz_stage_model.drive(MI, 8'h00, 1'b1);
      i_pz_stage_model.trail.delete();
      wait_zone(3'h1, 2400);
      check_data(32'(n >= 1850), 32'h1);
      wr(`PZ_OFS_CONFIG, 32'h00011008, OK);
      wait_zone(3'h4, 3000);
      check_trail(32'h1234);
      check_data(32'({phase_en, dcm_mode}), 32'h003);
      i_pz_stage_model.drive(MI, 8'hff, 1'b1);
      wait_zone(3'h0, 120);
      check_trail(32'h3210);
      i_pz_stage_model.drive(MI, 8'h78, 1'b1);
      stay(3'h0, 400);
      i_pz_stage_model.drive(MI, 8'h6f, 1'b1);
      wait_zone(3'h1, 400);
      stay(3'h1, 300);
      wr(`PZ_OFS_CONFIG, 32'h00010008, OK);
      i_pz_stage_model.drive(MI, 8'h5f, 1'b1);
      wait_zone(3'h2, 400);
      i_pz_stage_model.drive(MI, 8'h61, 1'b1);
      wait_zone(3'h1, 120);
      wr(`PZ_OFS_THRESH, 32'h8060ff20, OK);
      i_pz_stage_model.trail.delete();
      i_pz_stage_model.drive(MI, 8'h00, 1'b1);
      wait_zone(3'h4, 800);
      i_pz_stage_model.drive(MI, 8'hff, 1'b1);
      wait_zone(3'h0, 120);
      check_trail(32'h24210);
      i_pz_stage_model.drive(LO, 8'h00, 1'b1);
      wait_zone(3'h3, 800);
      check_trail(32'h123);
      wr(`PZ_OFS_FIXED, 32'h0000250c, OK);
      wait_zone(3'h4, 400);
      check_data(32'(frequency_set), 32'h25);
      rd(`PZ_OFS_FIXED, 32'h0000250c, OK);
      i_pz_stage_model.drive(MI, 8'h30, 1'b1);
      wait_zone(3'h2, 120);
      check_trail(32'h42);
      i_pz_stage_model.drive(HI, 8'h00, 1'b1);
      wait_zone(3'h0, 20);
      wr(`PZ_OFS_THRESH, 32'h80604020, OK);
      i_pz_stage_model.drive(LO, 8'h00, 1'b1);
      foreach (cfg[k]) begin
         wr(`PZ_OFS_CONFIG, {16'h0001, 12'h000, cfg[k][15:12]}, OK);
         wr(`PZ_OFS_FIXED, {16'h0000, 8'h25, 5'h01, cfg[k][10:8]}, OK);
         wait_zone(cfg[k][10:8], 1000);
         check_data(32'(phase_en), 32'(cfg[k][7:0]));
         check_data(32'(dcm_mode), 32'(cfg[k][10]));
      end
      // second reset in low hint: power-on strap again
      @(posedge aclk);
      do_reset();
      wait_zone(3'h4, 9000);
      report_and_stop();
   end
endmodule
`default_nettype wire
